/* hdl/digitizer_ctl_defines.vh */
// register map, field positions, reset values and timing counts for the
// video digitizer line control; included by the control module only
`ifndef DIGITIZER_CTL_DEFINES_VH
`define DIGITIZER_CTL_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_PIX_PER_LINE_HI 6'h01
`define IDX_PIX_PER_LINE_LO 6'h02
`define IDX_PHASE           6'h03
`define IDX_SOG_CTRL        6'h04
`define IDX_CONFIG          6'h05
`define IDX_RED_GAIN        6'h06
`define IDX_GREEN_GAIN      6'h07
`define IDX_BLUE_GAIN       6'h08
`define IDX_RED_OFFSET      6'h09
`define IDX_GREEN_OFFSET    6'h0a
`define IDX_BLUE_OFFSET     6'h0b
`define IDX_OFFSET_LSB      6'h0c
`define IDX_START_HI        6'h14
`define IDX_START_LO        6'h15
`define IDX_CLAMP_WIDTH     6'h16
`define IDX_SERVO_CTRL      6'h17
`define IDX_OUT_CTRL        6'h18
`define IDX_STATUS          6'h1e

// field positions
`define CFG_HS_ACTIVE_LOW   0
`define CFG_DC_COUPLED      1
`define CFG_LUMA_CHROMA     2
`define CFG_CLAMP_IN_COAST  5
`define CFG_SRC_LO          6
`define SERVO_DISABLE       0
`define OUT_DECIMATE        4

// sync source codes
`define SRC_SEPARATE        2'h0
`define SRC_COMPOSITE       2'h1
`define SRC_SOG             2'h2

// reset values
`define RST_PIX_PER_LINE    12'h540
`define RST_GAIN            8'h55
`define RST_OFFSET          8'h80
`define RST_START           16'h0018
`define RST_CLAMP_WIDTH     8'h08
`define RST_DAC             10'h200

// raw adc code the servo drives the black level to; mid-scale and user offset limits for the digital adjust
`define BLACK_PEDESTAL      8'h10
`define MID_SCALE           8'h80
`define USER_OFS_MIN        8'h40
`define USER_OFS_MAX        8'hc0

// sync activity window
`define ACT_WINDOW_US       5000
`define CLK_PERIOD_NS       5
`define ACT_WINDOW_CYCLES   (`ACT_WINDOW_US * 1000 / `CLK_PERIOD_NS)

`endif

/* hdl/video_digitizer_line_control.v */
// digital control around a three-channel video digitizer: register file,
// line timing, restore clamp, black-level servo and output mapping
// assumes adc samples and dpll coast arrive on pclk (the pixel clock);
// sync pins are asynchronous and resynchronised here
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "digitizer_ctl_defines.vh"

module video_digitizer_line_control #(
  parameter ACT_WINDOW = `ACT_WINDOW_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        hsync_in,
  input  wire        vsync_in,
  input  wire        sync_on_green_in,
  input  wire        dpll_coast,
  input  wire [7:0]  adc_red,
  input  wire [7:0]  adc_green,
  input  wire [7:0]  adc_blue,
  output reg  [7:0]  out_red,
  output reg  [7:0]  out_green,
  output reg  [7:0]  out_blue,
  output reg  [9:0]  dac_red,
  output reg  [9:0]  dac_green,
  output reg  [9:0]  dac_blue,
  output reg  [7:0]  gain_red,
  output reg  [7:0]  gain_green,
  output reg  [7:0]  gain_blue,
  output reg  [5:0]  phase_sel,
  output reg  [11:0] pix_per_line,
  output reg  [7:0]  sync_on_green_ctrl,
  output reg         dc_coupled,
  output reg         restore_clamp
);

  reg  [7:0]  cfg;
  reg  [7:0]  offset_r;
  reg  [7:0]  offset_g;
  reg  [7:0]  offset_b;
  reg  [7:0]  offset_lsb;
  reg  [15:0] clamp_start;
  reg  [7:0]  clamp_width;
  reg  [7:0]  servo_ctrl;
  reg  [7:0]  out_ctrl;
  reg  [2:0]  act_status;
  reg         all_nulled;
  wire [3:0]  status = {all_nulled, act_status};

  wire        setup = psel & ~penable;
  wire        wr_en = psel & penable & pready & pwrite & ~pslverr;
  wire [5:0]  idx   = paddr[7:2];
  reg         mapped;
  reg  [7:0]  rd_val;

  always @*
  begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `IDX_PIX_PER_LINE_HI: rd_val = {4'h0, pix_per_line[11:8]};
      `IDX_PIX_PER_LINE_LO: rd_val = pix_per_line[7:0];
      `IDX_PHASE:           rd_val = {2'h0, phase_sel};
      `IDX_SOG_CTRL:        rd_val = sync_on_green_ctrl;
      `IDX_CONFIG:          rd_val = cfg;
      `IDX_RED_GAIN:        rd_val = gain_red;
      `IDX_GREEN_GAIN:      rd_val = gain_green;
      `IDX_BLUE_GAIN:       rd_val = gain_blue;
      `IDX_RED_OFFSET:      rd_val = offset_r;
      `IDX_GREEN_OFFSET:    rd_val = offset_g;
      `IDX_BLUE_OFFSET:     rd_val = offset_b;
      `IDX_OFFSET_LSB:      rd_val = offset_lsb;
      `IDX_START_HI:        rd_val = clamp_start[15:8];
      `IDX_START_LO:        rd_val = clamp_start[7:0];
      `IDX_CLAMP_WIDTH:     rd_val = clamp_width;
      `IDX_SERVO_CTRL:      rd_val = servo_ctrl;
      `IDX_OUT_CTRL:        rd_val = out_ctrl;
      `IDX_STATUS:          rd_val = {4'h0, status};
      default:              mapped = 1'b0;
    endcase
  end

  // one wait-free access: pready rises the cycle after setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= {24'h000000, rd_val};
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pix_per_line       <= `RST_PIX_PER_LINE;
      phase_sel          <= 6'h00;
      sync_on_green_ctrl <= 8'h00;
      cfg                <= 8'h00;
      gain_red           <= `RST_GAIN;
      gain_green         <= `RST_GAIN;
      gain_blue          <= `RST_GAIN;
      offset_r           <= `RST_OFFSET;
      offset_g           <= `RST_OFFSET;
      offset_b           <= `RST_OFFSET;
      offset_lsb         <= 8'h00;
      clamp_start        <= `RST_START;
      clamp_width        <= `RST_CLAMP_WIDTH;
      servo_ctrl         <= 8'h00;
      out_ctrl           <= 8'h00;
    end
    else if (wr_en)
    begin
      case (idx)
        // all registers except status are programmed
        `IDX_PIX_PER_LINE_HI: pix_per_line[11:8] <= pwdata[3:0];
        `IDX_PIX_PER_LINE_LO: pix_per_line[7:0] <= pwdata[7:0];
        `IDX_PHASE:           phase_sel <= pwdata[5:0];
        `IDX_SOG_CTRL:        sync_on_green_ctrl <= pwdata[7:0];
        `IDX_CONFIG:          cfg <= pwdata[7:0];
        `IDX_RED_GAIN:        gain_red <= pwdata[7:0];
        `IDX_GREEN_GAIN:      gain_green <= pwdata[7:0];
        `IDX_BLUE_GAIN:       gain_blue <= pwdata[7:0];
        `IDX_RED_OFFSET:      offset_r <= pwdata[7:0];
        `IDX_GREEN_OFFSET:    offset_g <= pwdata[7:0];
        `IDX_BLUE_OFFSET:     offset_b <= pwdata[7:0];
        `IDX_OFFSET_LSB:      offset_lsb <= pwdata[7:0];
        `IDX_START_HI:        clamp_start[15:8] <= pwdata[7:0];
        `IDX_START_LO:        clamp_start[7:0] <= pwdata[7:0];
        `IDX_CLAMP_WIDTH:     clamp_width <= pwdata[7:0];
        `IDX_SERVO_CTRL:      servo_ctrl <= pwdata[7:0];
        `IDX_OUT_CTRL:        out_ctrl <= pwdata[7:0];
        default:              cfg <= cfg;
      endcase
    end
  end

  // two-flop resynchronisers for the sync pins
  reg [2:0] sync_meta;
  reg [2:0] sync_s;

  // source select; composite and separate both use the hsync pin
  wire [1:0] src     = cfg[`CFG_SRC_LO+1:`CFG_SRC_LO];
  wire       src_raw = (src == `SRC_SOG) ? sync_s[2] : sync_s[0];
  wire       line_sync = src_raw ^ cfg[`CFG_HS_ACTIVE_LOW];
  reg        line_sync_d;
  reg  [2:0] sync_d;
  wire       line_end = line_sync_d & ~line_sync;

  // edge activity per window, refreshed each window
  reg [31:0] act_cnt;
  reg [2:0]  act_seen;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_meta   <= 3'h0;
      sync_s      <= 3'h0;
      line_sync_d <= 1'b0;
      sync_d      <= 3'h0;
      act_cnt     <= 32'h00000000;
      act_seen    <= 3'h0;
      act_status  <= 3'h0;
    end
    else
    begin
      // only sync_s is read; sync_meta may be metastable
      sync_meta   <= {sync_on_green_in, vsync_in, hsync_in};
      sync_s      <= sync_meta;
      line_sync_d <= line_sync;
      sync_d      <= sync_s;
      if (act_cnt >= ACT_WINDOW - 1)
      begin
        act_cnt     <= 32'h00000000;
        act_status  <= act_seen | (sync_s ^ sync_d);
        act_seen    <= 3'h0;
      end
      else
      begin
        act_cnt  <= act_cnt + 32'h00000001;
        act_seen <= act_seen | (sync_s ^ sync_d);
      end
    end
  end

  // pixel count from trailing edge, saturating
  reg  [15:0] pix_cnt;
  reg         line_ok;
  wire        coast_block = dpll_coast & ~cfg[`CFG_CLAMP_IN_COAST];
  wire [16:0] clamp_end = {1'b0, clamp_start} + {9'h000, clamp_width};
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pix_cnt       <= 16'h0000;
      line_ok       <= 1'b0;
      restore_clamp <= 1'b0;
      dc_coupled    <= 1'b0;
    end
    else
    begin
      // coupling follows the config bit, AC at reset
      dc_coupled <= cfg[`CFG_DC_COUPLED];
      if (line_end)
      begin
        pix_cnt <= 16'h0000;
        // a coasting line gets no clamp or servo pass unless clamp-in-coast is set
        line_ok <= ~coast_block;
      end
      else if (pix_cnt != 16'hffff)
        pix_cnt <= pix_cnt + 16'h0001;
      restore_clamp <= ~line_end & line_ok & ~coast_block
                       & ~cfg[`CFG_DC_COUPLED]
                       & ({1'b0, pix_cnt} >= {1'b0, clamp_start})
                       & ({1'b0, pix_cnt} < clamp_end);
    end
  end

  // sample window shares the start count; 8 << sel pixels
  wire [1:0]  pix_sel  = servo_ctrl[3:2];
  wire [2:0]  line_sel = servo_ctrl[6:4];
  wire [16:0] samp_end = {1'b0, clamp_start} + ({9'h000, 8'h08} << pix_sel);
  wire        sampling = line_ok & ~line_end
                         & ({1'b0, pix_cnt} >= {1'b0, clamp_start})
                         & ({1'b0, pix_cnt} < samp_end);
  wire        samp_last = sampling & ({1'b0, pix_cnt} == samp_end - 17'h1);
  wire        servo_on = ~servo_ctrl[`SERVO_DISABLE];
  reg  [7:0]  line_cnt;
  wire        group_done = samp_last
                           & (line_cnt == (8'h01 << line_sel) - 8'h01);

  wire [23:0] adc_all = {adc_blue, adc_green, adc_red};
  wire [23:0] ofs_all = {offset_b, offset_g, offset_r};
  wire [29:0] servo_dac;
  wire [2:0]  nulled;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1)
    begin : chan
      reg  [13:0] pix_sum;
      reg  [14:0] line_sum;
      reg  [9:0]  dac;
      reg         hold;
      wire [13:0] pix_next = pix_sum + {6'h00, adc_all[ch*8+7:ch*8]};
      // shift count widened: a 2-bit sum would wrap for sel 1..3
      wire [13:0] pix_shr  = pix_next >> ({1'b0, pix_sel} + 3'h3);
      wire [7:0]  pix_avg  = pix_shr[7:0];
      wire [14:0] line_tot = line_sum + {7'h00, pix_avg};
      wire [14:0] line_shr = line_tot >> line_sel;
      wire [7:0]  line_avg = line_shr[7:0];
      assign servo_dac[ch*10+9:ch*10] = dac;
      assign nulled[ch] = hold;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pix_sum  <= 14'h0000;
          line_sum <= 15'h0000;
          dac      <= `RST_DAC;
          hold     <= 1'b0;
        end
        else if (!servo_on)
        begin
          pix_sum  <= 14'h0000;
          line_sum <= 15'h0000;
        end
        else if (sampling)
        begin
          // sum pixels, then lines, then compare
          pix_sum <= samp_last ? 14'h0000 : pix_next;
          if (samp_last)
            line_sum <= group_done ? 15'h0000 : line_tot;
          if (group_done)
          begin
            // one quarter-LSB step per group, none when nulled
            hold <= (line_avg == `BLACK_PEDESTAL);
            if (line_avg > `BLACK_PEDESTAL && dac != 10'h000)
              dac <= dac - 10'h001;
            else if (line_avg < `BLACK_PEDESTAL && dac != 10'h3ff)
              dac <= dac + 10'h001;
          end
        end
      end
    end
  endgenerate

  // manual dac values when the servo is off
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_red    <= `RST_DAC;
      dac_green  <= `RST_DAC;
      dac_blue   <= `RST_DAC;
      all_nulled <= 1'b0;
      line_cnt   <= 8'h00;
    end
    else if (servo_on)
    begin
      dac_red    <= servo_dac[9:0];
      dac_green  <= servo_dac[19:10];
      dac_blue   <= servo_dac[29:20];
      all_nulled <= &nulled;
      if (samp_last)
        line_cnt <= group_done ? 8'h00 : line_cnt + 8'h01;
    end
    else
    begin
      dac_red    <= {offset_r, offset_lsb[7:6]};
      dac_green  <= {offset_g, offset_lsb[5:4]};
      dac_blue   <= {offset_b, offset_lsb[3:2]};
      all_nulled <= 1'b0;
      line_cnt   <= 8'h00;
    end
  end

  // digital black adjust: pedestal removed, user
  // offset limited to +-64, chroma lifted to mid-scale
  function [7:0] adjust;
    input [7:0] raw;
    input [7:0] user;
    input       chroma;
    reg   [7:0] lim;
    reg   [10:0] sum;
    begin
      lim = (user < `USER_OFS_MIN) ? `USER_OFS_MIN :
            (user > `USER_OFS_MAX) ? `USER_OFS_MAX : user;
      sum = {3'h0, raw} - {3'h0, `BLACK_PEDESTAL} + {3'h0, lim}
            - {3'h0, `MID_SCALE} + (chroma ? {3'h0, `MID_SCALE} : 11'h000);
      if (sum[10])
        adjust = 8'h00;
      else if (sum[9:8] != 2'h0)
        adjust = 8'hff;
      else
        adjust = sum[7:0];
    end
  endfunction

  wire       chroma_mode = cfg[`CFG_LUMA_CHROMA];
  wire       decimate    = chroma_mode & out_ctrl[`OUT_DECIMATE];
  wire       adj_en      = servo_on;
  wire [7:0] adj_r = adj_en ? adjust(adc_red, offset_r, chroma_mode) : adc_red;
  wire [7:0] adj_g = adj_en ? adjust(adc_green, offset_g, 1'b0) : adc_green;
  wire [7:0] adj_b = adj_en ? adjust(adc_blue, offset_b, chroma_mode)
                            : adc_blue;
  reg        pick_v;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_red   <= 8'h00;
      out_green <= 8'h00;
      out_blue  <= 8'h00;
      pick_v    <= 1'b0;
    end
    else
    begin
      // luma stays on green in every mode
      out_green <= adj_g;
      pick_v    <= line_end ? 1'b0 : ~pick_v;
      if (decimate)
      begin
        // U on even pixels, V on odd, blue driven low
        out_red  <= pick_v ? adj_r : adj_b;
        out_blue <= 8'h00;
      end
      else
      begin
        out_red  <= adj_r;
        out_blue <= adj_b;
      end
    end
  end

endmodule // video_digitizer_line_control

/* tb/digitizer_chk.sv */
// checker for the digitizer line control, bound to its top module
// follows the register writes it needs from the apb pins alone
`timescale 1ns/100ps
module digitizer_chk #(
  parameter ACT_WINDOW = 64
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        dpll_coast,
  input wire [7:0]  out_red,
  input wire [7:0]  out_blue,
  input wire [9:0]  dac_red,
  input wire [7:0]  gain_red,
  input wire        restore_clamp
);
  wire      wr = psel && penable && pready && pwrite;
  reg [7:0] cfg;
  reg [7:0] wid;
  reg [7:0] srv;
  reg [7:0] oc;
  reg [8:0] run;
  reg       touched;
  wire      man = srv[0];
  wire      dcm = cfg[1];
  wire      cok = cfg[5];
  wire      dec = oc[4] && cfg[2];
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cfg <= 8'h00;
      wid <= 8'h08;
      srv <= 8'h00;
      oc <= 8'h00;
      run <= 9'h000;
      touched <= 1'b0;
    end
    else
    begin
      if (wr && paddr == 8'h14)
        cfg <= pwdata[7:0];
      if (wr && paddr == 8'h58)
        wid <= pwdata[7:0];
      if (wr && paddr == 8'h5c)
        srv <= pwdata[7:0];
      if (wr && paddr == 8'h60)
        oc <= pwdata[7:0];
      run <= restore_clamp ? run + 9'h001 : 9'h000;
      // a write inside the window may cut it short legally
      touched <= restore_clamp && (touched || wr);
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SETUP_ANSWER:
    assert property (psel && !penable |=> pready) else $error("no answer");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_EMPTY:
    assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error reply");
  AST_RDATA_BYTE:
    assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
  AST_GAIN_WRITE:
    assert property (wr && paddr == 8'h18
      |=> {24'h0, gain_red} == $past(pwdata)) else $error("gain write lost");
  AST_DAC_STEP:
    assert property ($changed(dac_red) && !man && !$past(man) && !$past(man, 2)
      |-> dac_red == $past(dac_red) + 10'h001
        || dac_red == $past(dac_red) - 10'h001) else $error("dac jump");
  AST_CLAMP_WIDTH:
    assert property ($fell(restore_clamp) && !touched && !$past(dpll_coast)
      && !$past(dpll_coast, 2) |-> run == {1'b0, wid})
      else $error("clamp width wrong");
  AST_DC_NO_CLAMP:
    assert property (dcm && $past(dcm, 3) |-> !restore_clamp)
      else $error("clamp in dc mode");
  AST_COAST_NO_CLAMP:
    assert property ($past(dpll_coast, 2) && $past(dpll_coast) && !cok
      && !$past(cok, 2) |-> !restore_clamp) else $error("clamp in coast");
  AST_DEC_BLUE_LOW:
    assert property (dec && $past(dec, 2) |-> out_blue == 8'h00)
      else $error("blue not low");
  COV_CLAMP: cover property ($rose(restore_clamp));
  COV_ERR: cover property (pslverr);
  COV_DEC: cover property (dec && out_red != 8'h00);
endmodule // digitizer_chk

bind video_digitizer_line_control digitizer_chk #(
  .ACT_WINDOW(ACT_WINDOW)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dpll_coast(dpll_coast),
  .out_red(out_red), .out_blue(out_blue), .dac_red(dac_red),
  .gain_red(gain_red), .restore_clamp(restore_clamp));

/* tb/video_src.sv */
// video source model: separate active-high line sync, flat levels
// levels and coasting come from the bench; lines are LINE pixels
`timescale 1ns/100ps
module video_src #(
  parameter [7:0] LINE = 8'h64,
  parameter [7:0] SYNC = 8'h08
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       coast_req,
  input  wire [7:0] lvl_r,
  input  wire [7:0] lvl_g,
  input  wire [7:0] lvl_b,
  output reg        hsync_in,
  output reg        vsync_in,
  output reg        sync_on_green_in,
  output reg        dpll_coast,
  output reg  [7:0] adc_red,
  output reg  [7:0] adc_green,
  output reg  [7:0] adc_blue
);
  reg [7:0] pix;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pix <= 8'h00;
      {hsync_in, vsync_in, sync_on_green_in, dpll_coast} <= 4'h0;
      {adc_red, adc_green, adc_blue} <= 24'h000000;
    end
    else
    begin
      pix <= (pix == LINE - 8'h01) ? 8'h00 : pix + 8'h01;
      hsync_in <= (pix < SYNC);
      vsync_in <= 1'b0;
      sync_on_green_in <= 1'b0;
      dpll_coast <= coast_req;
      {adc_red, adc_green, adc_blue} <= {lvl_r, lvl_g, lvl_b};
    end
endmodule // video_src

/* tb/video_digitizer_line_control_tb_top.sv */
// self-checking bench for the digitizer line control
// apb master tasks plus the video source model; pclk at 200 MHz
`timescale 1ns/100ps
module video_digitizer_line_control_tb_top;
  reg         pclk, presetn, psel, penable, pwrite, coast, er;
  reg  [7:0]  paddr, lr, lg, lb;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  v [0:2];
  reg  [39:0] ofs = 40'h80c0ff4000;
  reg  [39:0] exo = 40'h5090901010;
  wire [31:0] prdata;
  wire        pready, pslverr, hs, vs, sync_on_green, cst, clamp, dcc;
  wire [7:0]  ar, ag, ab, o_r, o_g, o_b, g_r, g_g, g_b, sgc;
  wire [9:0]  d_r, d_g, d_b;
  wire [5:0]  ph;
  wire [11:0] ppl;
  integer     num_errors, check_count, i, n, dl, len, cn;

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  video_src u_src (
    .pclk(pclk), .presetn(presetn), .coast_req(coast), .lvl_r(lr),
    .lvl_g(lg), .lvl_b(lb), .hsync_in(hs), .vsync_in(vs),
    .sync_on_green_in(sync_on_green), .dpll_coast(cst), .adc_red(ar),
    .adc_green(ag), .adc_blue(ab));

  // short activity window so status settles within a few lines
  video_digitizer_line_control #(.ACT_WINDOW(256)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hsync_in(hs), .vsync_in(vs),
    .sync_on_green_in(sync_on_green), .dpll_coast(cst), .adc_red(ar),
    .adc_green(ag), .adc_blue(ab), .out_red(o_r), .out_green(o_g),
    .out_blue(o_b), .dac_red(d_r), .dac_green(d_g), .dac_blue(d_b),
    .gain_red(g_r), .gain_green(g_g), .gain_blue(g_b), .phase_sel(ph),
    .pix_per_line(ppl), .sync_on_green_ctrl(sgc), .dc_coupled(dcc),
    .restore_clamp(clamp));

  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task final_report;
  begin
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // starts on its own edge so a release and a new setup never collide
  task apb(input w, input [5:0] a, input [7:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready is read as sampled at this rising edge
    for (n = 0; pready !== 1'b1 && n < 20; n = n + 1)
      @(posedge pclk);
    if (n == 20)
    begin
      num_errors = num_errors + 1;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task rc(input [5:0] a, input [31:0] e);
  begin
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  end
  endtask

  // cycles from sync trailing edge to clamp, then clamp length
  task meas;
  begin
    for (n = 0; hs !== 1'b1 && n < 300; n = n + 1) @(posedge pclk);
    for (dl = n; hs !== 1'b0 && dl < 300; dl = dl + 1) @(posedge pclk);
    // no sync edge at all ends the run as a failure
    if (dl >= 300)
    begin
      num_errors = num_errors + 1;
      final_report;
    end
    for (dl = 0; clamp !== 1'b1 && dl < 300; dl = dl + 1) @(posedge pclk);
    for (len = 0; clamp === 1'b1 && len < 300; len = len + 1)
      @(posedge pclk);
  end
  endtask

  // clamp cycles over exactly two lines
  task cnt;
  begin
    repeat (100) @(posedge pclk);
    cn = 0;
    repeat (200)
    begin
      @(posedge pclk);
      if (clamp === 1'b1)
        cn = cn + 1;
    end
  end
  endtask

  initial
  begin
    num_errors = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, coast} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {lr, lg, lb} = 24'h101010;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 6; i < 9; i = i + 1)
      rc(i[5:0], 32'h55);
    chk(ppl, 12'h540);
    rc(6'h09, 32'h80);
    rc(6'h15, 32'h18);
    rc(6'h16, 32'h08);
    apb(1'b1, 6'h03, 8'h3f);
    // register copies update on the write edge itself
    @(negedge pclk);
    chk(ph, 6'h3f);
    apb(1'b1, 6'h04, 8'h5a);
    @(negedge pclk);
    chk(sgc, 8'h5a);
    apb(1'b1, 6'h06, 8'h12);
    apb(1'b1, 6'h07, 8'h34);
    apb(1'b1, 6'h08, 8'hff);
    @(negedge pclk);
    chk({g_r, g_g, g_b}, 24'h1234ff);
    chk(d_g, 10'h200);
    apb(1'b0, 6'h3f, 8'h00);
    chk(er, 1);
    chk(rd, 0);
    lr <= 8'h14;
    repeat (800) @(posedge pclk);
    chk(d_r != 10'h200, 1);
    chk(d_g, 10'h200);
    lr <= 8'h60;
    for (i = 0; i < 5; i = i + 1)
    begin
      apb(1'b1, 6'h09, ofs[39 - 8 * i -: 8]);
      repeat (3) @(posedge pclk);
      chk(o_r, exo[39 - 8 * i -: 8]);
    end
    apb(1'b1, 6'h09, 8'h80);
    lr <= 8'h10;
    apb(1'b1, 6'h05, 8'h04);
    repeat (3) @(posedge pclk);
    chk({o_r, o_g, o_b}, 24'h800080);
    rc(6'h05, 32'h04);
    apb(1'b1, 6'h17, 8'h01);
    lr <= 8'h33;
    lb <= 8'h77;
    apb(1'b1, 6'h18, 8'h10);
    // line-aligned so no line start splits the U/V pairs
    meas;
    repeat (3) @(posedge pclk);
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge pclk);
      v[i] = o_r;
    end
    chk(o_b, 8'h00);
    chk(v[0] ^ v[1], 8'h44);
    chk(v[0] & v[1], 8'h33);
    chk(v[0], v[2]);
    apb(1'b1, 6'h18, 8'h00);
    repeat (3) @(posedge pclk);
    chk({o_r, o_g, o_b}, 24'h331077);
    apb(1'b1, 6'h09, 8'h9a);
    apb(1'b1, 6'h0c, 8'hcc);
    repeat (3) @(posedge pclk);
    chk(d_r, 10'h26b);
    chk(d_b, 10'h203);
    apb(1'b1, 6'h05, 8'h00);
    apb(1'b1, 6'h16, 8'h05);
    apb(1'b1, 6'h15, 8'h20);
    meas;
    chk(len, 5);
    chk(dl >= 35 && dl <= 37, 1);
    apb(1'b1, 6'h15, 8'h50);
    meas;
    chk(dl >= 83 && dl <= 85, 1);
    apb(1'b1, 6'h15, 8'h20);
    coast <= 1'b1;
    cnt;
    chk(cn, 0);
    apb(1'b1, 6'h05, 8'h20);
    cnt;
    chk(cn, 10);
    coast <= 1'b0;
    apb(1'b1, 6'h05, 8'h02);
    cnt;
    chk(cn, 0);
    chk(dcc, 1);
    apb(1'b0, 6'h1e, 8'h00);
    chk(rd[2:0], 3'h1);
    final_report;
  end
endmodule // video_digitizer_line_control_tb_top
